// >>> add_sub_pkg.sv
// Purpose: Shared constants and carriers for the add/subtract datapath
// Assumes: One 32-bit core clock, operands already read from the register file
// Notes:   Register offsets are byte addresses on the plain register port
package add_sub_pkg;

    // Datapath widths
    localparam int unsigned WORD_W   = 32;
    localparam int unsigned IDX_W    = 4;
    localparam int unsigned IMM_W    = 12;
    localparam int unsigned ADDR_W   = 8;

    // Architectural register indices used by the special forms
    localparam logic [IDX_W-1:0] SP_IDX = 4'hd;
    localparam logic [IDX_W-1:0] PC_IDX = 4'hf;

    // Register offsets
    localparam logic [ADDR_W-1:0] FLAGS_OFF  = 8'h00;
    localparam logic [ADDR_W-1:0] RESULT_OFF = 8'h04;
    localparam logic [ADDR_W-1:0] COUNT_OFF  = 8'h08;
    localparam logic [ADDR_W-1:0] REJECT_OFF = 8'h0c;

    // Flag field positions inside the flags register
    localparam int unsigned FLAG_V = 0;
    localparam int unsigned FLAG_C = 1;
    localparam int unsigned FLAG_Z = 2;
    localparam int unsigned FLAG_N = 3;
    localparam int unsigned FLAGS_W = 4;

    // Reset values
    localparam logic [FLAGS_W-1:0] FLAGS_RST = 4'h0;
    localparam logic [WORD_W-1:0]  WORD_RST  = 32'h0000_0000;

    // Address clearing masks for the program counter forms
    localparam logic [WORD_W-1:0] WORD_ALIGN_MASK = 32'hffff_fffc;
    localparam logic [WORD_W-1:0] HALF_ALIGN_MASK = 32'hffff_fffe;

    // Operation codes, one-hot
    typedef enum logic [4:0] {
        OP_SUM       = 5'b00001,
        OP_SUM_CARRY = 5'b00010,
        OP_DIFF      = 5'b00100,
        OP_DIFF_BRW  = 5'b01000,
        OP_REV_DIFF  = 5'b10000
    } op_t;

    // Issue request from the core
    typedef struct packed {
        logic              valid;
        op_t               op;
        logic              set_flags;
        logic              use_imm;
        logic [IMM_W-1:0]  imm;
        logic [IDX_W-1:0]  first_idx;
        logic [WORD_W-1:0] first_val;
        logic [WORD_W-1:0] second_val;
        logic              dest_present;
        logic [IDX_W-1:0]  dest_idx;
    } req_t;

    // Write-back to the register file
    typedef struct packed {
        logic              valid;
        logic [IDX_W-1:0]  idx;
        logic [WORD_W-1:0] data;
    } wb_t;

    // Branch request to the fetch stage
    typedef struct packed {
        logic              valid;
        logic [WORD_W-1:0] target;
    } branch_t;

endpackage

// >>> carry_adder.sv
// Purpose: Ripple-free adder with carry in, carry out and signed overflow
// Assumes: Caller inverts operands for subtraction
// Notes:   Width is a parameter; results below two bits make no sense
module carry_adder #(
    parameter int unsigned WIDTH = 32
) (
    // Operands
    input  wire logic [WIDTH-1:0] a_in,
    input  wire logic [WIDTH-1:0] b_in,
    input  wire logic             carry_in,
    // Results
    output logic      [WIDTH-1:0] sum_out,
    output logic                  carry_out,
    output logic                  overflow_out
);

    // Refuse widths the sign logic cannot serve
    if (WIDTH < 2) begin : g_width_check
        $error("carry_adder width must be at least 2");
    end

    logic [WIDTH:0] full_sum;

    // One extra bit catches the carry out
    assign full_sum     = {1'b0, a_in} + {1'b0, b_in} + {{WIDTH{1'b0}}, carry_in};
    assign sum_out      = full_sum[WIDTH-1:0];
    assign carry_out    = full_sum[WIDTH];
    // Overflow when like-signed inputs give an unlike-signed sum
    assign overflow_out = (a_in[WIDTH-1] == b_in[WIDTH-1]) && (sum_out[WIDTH-1] != a_in[WIDTH-1]);

endmodule

// >>> integer_add_subtract_unit.sv
// Purpose: Add/subtract stage of the core with flags and PC-relative forms
// Assumes: Operand values arrive read; the flexible operand is already shifted
// Notes:   One request per cycle, result one cycle after the request edge
//
// Operation
// - A sum writes the first operand plus the flexible operand or the 12-bit immediate.
// - A sum with carry adds the first operand, the flexible operand and the carry flag.
// - A difference writes the first operand minus the flexible operand or the immediate.
// - A difference with borrow subtracts one more when the carry flag is clear.
// - A reversed difference writes the flexible operand minus the first operand.
// - The immediate form exists only for sum and difference, spans 0 to 4095 and leaves the flags alone.
// - With no destination given the result goes back to the first operand register.
// - With flag update requested, N, Z, C and V follow the result of any of the five operations.
// - A program counter used as first operand has its two low bits cleared before the arithmetic.
// - The PC-plus-register sum with the PC as destination branches to the result with bit zero cleared.
// - The wide immediate sum and difference run exactly as the 12-bit immediate forms.
//
// Added by the designer: strobed register access and the register offsets.
module integer_add_subtract_unit (
    // Clock and reset
    input  wire logic                              clk,
    input  wire logic                              reset_n,
    // Issue request
    input  add_sub_pkg::req_t                      req_in,
    // Write-back, branch and flags
    output add_sub_pkg::wb_t                       wb_out,
    output add_sub_pkg::branch_t                   branch_out,
    output logic [add_sub_pkg::FLAGS_W-1:0]        flags_out,
    // Register port
    input  wire logic [add_sub_pkg::ADDR_W-1:0]    reg_addr,
    input  wire logic [add_sub_pkg::WORD_W-1:0]    reg_wdata,
    input  wire logic                              reg_wr,
    input  wire logic                              reg_rd,
    output logic      [add_sub_pkg::WORD_W-1:0]    reg_rdata
);
    import add_sub_pkg::*;

    // State
    logic [FLAGS_W-1:0] flags_reg;
    logic [FLAGS_W-1:0] flags_next;
    wb_t                wb_reg;
    wb_t                wb_next;
    branch_t            branch_reg;
    branch_t            branch_next;
    logic [WORD_W-1:0]  result_reg;
    logic [WORD_W-1:0]  count_reg;
    logic [WORD_W-1:0]  reject_reg;
    logic [WORD_W-1:0]  rdata_reg;
    logic [WORD_W-1:0]  rdata_next;

    // Decode
    logic               carry_flag;
    logic               first_is_pc;
    logic [WORD_W-1:0]  base_a;
    logic [WORD_W-1:0]  opnd_b;
    logic [IDX_W-1:0]   dest_idx;
    logic               imm_allowed;
    logic               op_known;
    logic               legal;
    logic               take;
    logic               reject;
    logic               is_branch;
    logic               flag_update;

    // Adder hookup
    logic [WORD_W-1:0]  add_a;
    logic [WORD_W-1:0]  add_b;
    logic               add_cin;
    logic [WORD_W-1:0]  add_sum;
    logic               add_cout;
    logic               add_ovf;
    logic [FLAGS_W-1:0] new_flags;

    // Register port decode
    logic               sel_flags;
    logic               sel_result;
    logic               sel_count;
    logic               sel_reject;
    logic               sw_flags_wr;
    logic [WORD_W-1:0]  read_mux;

    assign carry_flag  = flags_reg[FLAG_C];

    // PC base is word aligned so PC-relative constants land on words
    assign first_is_pc = (req_in.first_idx == PC_IDX);
    assign base_a      = first_is_pc ? (req_in.first_val & WORD_ALIGN_MASK)
                                     : req_in.first_val;
    // Immediate is zero extended, so it always reads 0 to 4095
    assign opnd_b      = req_in.use_imm ? {{(WORD_W-IMM_W){1'b0}}, req_in.imm}
                                        : req_in.second_val;
    // Omitted destination falls back to the first operand register
    assign dest_idx    = req_in.dest_present ? req_in.dest_idx : req_in.first_idx;

    // Legality: immediate only on sum and difference, op code must be one-hot
    assign op_known    = (req_in.op == OP_SUM) || (req_in.op == OP_SUM_CARRY) || (req_in.op == OP_DIFF)
                         || (req_in.op == OP_DIFF_BRW) || (req_in.op == OP_REV_DIFF);
    assign imm_allowed = (req_in.op == OP_SUM) || (req_in.op == OP_DIFF);
    assign legal       = op_known && (!req_in.use_imm || imm_allowed);
    assign take        = req_in.valid && legal;
    assign reject      = req_in.valid && !legal;

    // PC-plus-register form turns into a branch; flag-free use is the caller's duty
    assign is_branch   = take && (req_in.op == OP_SUM) && !req_in.use_imm && first_is_pc
                         && (dest_idx == PC_IDX);
    // Immediate forms never touch the flags
    assign flag_update = take && req_in.set_flags && !req_in.use_imm;

    // Operand steering; subtraction is addition of the inverse
    always_comb begin
        add_a   = base_a;
        add_b   = opnd_b;
        add_cin = 1'b0;
        unique case (req_in.op)
            OP_SUM: begin
                add_cin = 1'b0;
            end
            OP_SUM_CARRY: begin
                add_cin = carry_flag;
            end
            OP_DIFF: begin
                add_b   = ~opnd_b;
                add_cin = 1'b1;
            end
            OP_DIFF_BRW: begin
                add_b   = ~opnd_b;
                add_cin = carry_flag;
            end
            OP_REV_DIFF: begin
                add_a   = opnd_b;
                add_b   = ~base_a;
                add_cin = 1'b1;
            end
            default: begin
                add_cin = 1'b0;
            end
        endcase
    end

    carry_adder #(
        .WIDTH        (WORD_W)
    ) u_adder (
        .a_in         (add_a),
        .b_in         (add_b),
        .carry_in     (add_cin),
        .sum_out      (add_sum),
        .carry_out    (add_cout),
        .overflow_out (add_ovf)
    );

    // Carry out of a + ~b + 1 is the no-borrow bit, which chains across words
    assign new_flags[FLAG_N] = add_sum[WORD_W-1];
    assign new_flags[FLAG_Z] = (add_sum == WORD_RST);
    assign new_flags[FLAG_C] = add_cout;
    assign new_flags[FLAG_V] = add_ovf;

    // Register port decode
    assign sel_flags   = (reg_addr == FLAGS_OFF);
    assign sel_result  = (reg_addr == RESULT_OFF);
    assign sel_count   = (reg_addr == COUNT_OFF);
    assign sel_reject  = (reg_addr == REJECT_OFF);
    assign sw_flags_wr = reg_wr && sel_flags;
    assign read_mux    = sel_flags  ? {{(WORD_W-FLAGS_W){1'b0}}, flags_reg} :
                         sel_result ? result_reg :
                         sel_count  ? count_reg  :
                         sel_reject ? reject_reg : WORD_RST;

    // Hardware flag update beats a software write in the same cycle
    assign flags_next = flag_update ? new_flags :
                        sw_flags_wr ? reg_wdata[FLAGS_W-1:0] : flags_reg;

    // Branch target drops bit zero; it does not write the register file
    assign branch_next.valid  = is_branch;
    assign branch_next.target = add_sum & HALF_ALIGN_MASK;
    assign wb_next.valid      = take && !is_branch;
    assign wb_next.idx        = dest_idx;
    assign wb_next.data       = add_sum;

    // Read data stand for one cycle only, zero otherwise
    assign rdata_next = reg_rd ? read_mux : WORD_RST;

    // Result and flag state
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            flags_reg  <= FLAGS_RST;
            wb_reg     <= '0;
            branch_reg <= '0;
        end else begin
            flags_reg  <= flags_next;
            wb_reg     <= wb_next;
            branch_reg <= branch_next;
        end
    end

    // Software-visible status
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            result_reg <= WORD_RST;
            count_reg  <= WORD_RST;
            reject_reg <= WORD_RST;
            rdata_reg  <= WORD_RST;
        end else begin
            if (take) begin
                result_reg <= add_sum;
                count_reg  <= count_reg + 32'h0000_0001;
            end
            if (reject) begin
                reject_reg <= reject_reg + 32'h0000_0001;
            end
            rdata_reg <= rdata_next;
        end
    end

    assign wb_out     = wb_reg;
    assign branch_out = branch_reg;
    assign flags_out  = flags_reg;
    assign reg_rdata  = rdata_reg;

    // Reference values, written apart from the adder path
    logic [WORD_W-1:0] exp_sum;
    logic [WORD_W-1:0] exp_sum_c;
    logic [WORD_W-1:0] exp_diff;
    logic [WORD_W-1:0] exp_diff_b;
    logic [WORD_W-1:0] exp_rev;
    logic              exp_no_borrow;
    logic              is_sub;

    assign exp_sum       = base_a + opnd_b;
    assign exp_sum_c     = base_a + opnd_b + {{(WORD_W-1){1'b0}}, carry_flag};
    assign exp_diff      = base_a - opnd_b;
    assign exp_diff_b    = base_a - opnd_b - {{(WORD_W-1){1'b0}}, !carry_flag};
    assign exp_rev       = opnd_b - base_a;
    assign exp_no_borrow = (req_in.op == OP_REV_DIFF) ? (opnd_b >= base_a) : (base_a >= opnd_b);
    assign is_sub        = (req_in.op == OP_DIFF) || (req_in.op == OP_REV_DIFF);

    // Sum flags, aligned PC base and widened immediate, kept apart from the adder
    logic              exp_sum_cout;
    logic              exp_sum_ovf;
    logic [WORD_W-1:0] exp_pc_base;
    logic [WORD_W-1:0] exp_imm;

    // A sum carries out exactly when a exceeds the room left above b
    assign exp_sum_cout  = (base_a > ~opnd_b);
    assign exp_sum_ovf   = ($signed(base_a) < 0) == ($signed(opnd_b) < 0)
                           && (($signed(exp_sum) < 0) != ($signed(base_a) < 0));
    assign exp_pc_base   = {req_in.first_val[WORD_W-1:2], 2'b00};
    assign exp_imm       = {{(WORD_W-IMM_W){1'b0}}, req_in.imm};

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    sum_result_a: assert property (
        take && (req_in.op == OP_SUM) && !is_branch |=> wb_reg.valid && (wb_reg.data == $past(exp_sum))
    ) else $error("sum result wrong");

    carry_sum_a: assert property (
        take && (req_in.op == OP_SUM_CARRY) |=> wb_reg.valid && (wb_reg.data == $past(exp_sum_c))
    ) else $error("sum with carry result wrong");

    diff_result_a: assert property (
        take && (req_in.op == OP_DIFF) |=> wb_reg.data == $past(exp_diff)
    ) else $error("difference result wrong");

    borrow_diff_a: assert property (
        take && (req_in.op == OP_DIFF_BRW) |=> wb_reg.data == $past(exp_diff_b)
    ) else $error("difference with borrow result wrong");

    rev_diff_a: assert property (
        take && (req_in.op == OP_REV_DIFF) |=> wb_reg.data == $past(exp_rev)
    ) else $error("reversed difference result wrong");

    imm_flags_a: assert property (
        req_in.valid && req_in.use_imm && !sw_flags_wr |=> $stable(flags_reg)
    ) else $error("immediate form changed flags");

    imm_reject_a: assert property (
        req_in.valid && req_in.use_imm && !imm_allowed |=> !wb_reg.valid && !branch_reg.valid
    ) else $error("immediate accepted on wrong operation");

    dest_default_a: assert property (
        take && !req_in.dest_present && !is_branch |=> wb_reg.idx == $past(req_in.first_idx)
    ) else $error("default destination wrong");

    nz_flags_a: assert property (
        flag_update |=> (flags_reg[FLAG_Z] == (wb_reg.data == WORD_RST))
                        && (flags_reg[FLAG_N] == wb_reg.data[WORD_W-1])
    ) else $error("N or Z flag does not follow result");

    pc_align_a: assert property (
        take && first_is_pc && (req_in.op == OP_SUM) && !is_branch
        |=> wb_reg.data[1:0] == $past(opnd_b[1:0])
    ) else $error("PC base not word aligned");

    branch_target_a: assert property (
        is_branch |=> branch_reg.valid && !wb_reg.valid && !branch_reg.target[0]
                      && (branch_reg.target[WORD_W-1:1] == $past(exp_sum[WORD_W-1:1]))
    ) else $error("branch target wrong");

    no_borrow_a: assert property (
        flag_update && is_sub |=> flags_reg[FLAG_C] == $past(exp_no_borrow)
    ) else $error("subtract carry is not the no-borrow bit");

    // Carry and overflow of plain sums, the chaining bits for multiword adds
    sum_carry_flag_a: assert property (
        flag_update && (req_in.op == OP_SUM) |=> flags_reg[FLAG_C] == $past(exp_sum_cout)
    ) else $error("sum carry flag wrong");

    sum_overflow_a: assert property (
        flag_update && (req_in.op == OP_SUM) |=> flags_reg[FLAG_V] == $past(exp_sum_ovf)
    ) else $error("sum overflow flag wrong");

    // PC-relative difference must use the aligned base too
    pc_diff_base_a: assert property (
        take && first_is_pc && (req_in.op == OP_DIFF) |=> wb_reg.data == $past(exp_pc_base - opnd_b)
    ) else $error("PC based difference not word aligned");

    // Wide immediate forms are the zero-extended 12-bit forms
    wide_imm_sum_a: assert property (
        take && req_in.use_imm && (req_in.op == OP_SUM) |=> wb_reg.valid && (wb_reg.data == $past(base_a + exp_imm))
    ) else $error("wide immediate sum wrong");

    wide_imm_diff_a: assert property (
        take && req_in.use_imm && (req_in.op == OP_DIFF) |=> wb_reg.valid && (wb_reg.data == $past(base_a - exp_imm))
    ) else $error("wide immediate difference wrong");

    // A refused request leaves nothing behind but its count
    refuse_quiet_a: assert property (
        reject && !sw_flags_wr |=> !wb_reg.valid && !branch_reg.valid && $stable(flags_reg)
    ) else $error("refused request left a trace");

    refuse_count_a: assert property (
        reject |=> reject_reg == $past(reject_reg) + 32'h0000_0001
    ) else $error("refusal not counted");

    branch_seen_c: cover property (is_branch ##1 branch_reg.valid);
    carry_used_c:  cover property (take && (req_in.op == OP_SUM_CARRY) && carry_flag);
    borrow_used_c: cover property (take && (req_in.op == OP_DIFF_BRW) && !carry_flag && req_in.set_flags);
    imm_sum_c:     cover property (take && req_in.use_imm && (req_in.imm == 12'hfff));
    refused_c:     cover property (reject && !req_in.use_imm);

endmodule

// >>> tb_top.sv
// Purpose: Self-checking bench for the add/subtract stage
// Assumes: Result and branch one cycle after the request edge
// Notes:   Expected values come from a local arithmetic model and from fixed constants
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import add_sub_pkg::*;

    // Stimulus and observed signals
    logic                clk;
    logic                reset_n;
    req_t                req;
    wb_t                 wb;
    branch_t             br;
    logic [FLAGS_W-1:0]  flags;
    logic [ADDR_W-1:0]   reg_addr;
    logic [WORD_W-1:0]   reg_wdata;
    logic                reg_wr;
    logic                reg_rd;
    logic [WORD_W-1:0]   reg_rdata;
    logic [FLAGS_W-1:0]  exp_f;
    int                  err_count;
    int                  compares;

    integer_add_subtract_unit u_integer_add_subtract_unit (
        .clk        (clk),
        .reset_n    (reset_n),
        .req_in     (req),
        .wb_out     (wb),
        .branch_out (br),
        .flags_out  (flags),
        .reg_addr   (reg_addr),
        .reg_wdata  (reg_wdata),
        .reg_wr     (reg_wr),
        .reg_rd     (reg_rd),
        .reg_rdata  (reg_rdata)
    );

    // Free-running 100 MHz core clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic wrap_up();
        if (err_count == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] want, input string msg);
        compares++;
        if (got !== want) begin
            err_count++;
            $display("BAD %0t %s got %h want %h", $time, msg, got, want);
        end
    endtask

    // Model: {N,Z,C,V,result}; subtracts add the inverse so C means no borrow
    function automatic logic [35:0] calc(op_t op, logic [31:0] a, logic [31:0] b, logic cf);
        logic [32:0] s;
        logic [31:0] x;
        logic [31:0] y;
        logic        ci;
        logic        v;
        x = a;
        y = b;
        ci = 1'b0;
        case (op)
            OP_SUM_CARRY: ci = cf;
            OP_DIFF:      begin y = ~b; ci = 1'b1; end
            OP_DIFF_BRW:  begin y = ~b; ci = cf; end
            OP_REV_DIFF:  begin x = b; y = ~a; ci = 1'b1; end
            default:      ci = 1'b0;
        endcase
        s = {1'b0, x} + {1'b0, y} + {32'h0000_0000, ci};
        v = (x[31] == y[31]) && (s[31] != x[31]);
        return {s[31], s[31:0] == 32'h0000_0000, s[32], v, s[31:0]};
    endfunction

    function automatic req_t mk(op_t op, logic sf, logic ui, logic [11:0] imm, logic [3:0] fi,
                                logic [31:0] fv, logic [31:0] sv, logic dp, logic [3:0] di);
        mk = '0;
        mk.valid = 1'b1;
        mk.op = op;
        mk.set_flags = sf;
        mk.use_imm = ui;
        mk.imm = imm;
        mk.first_idx = fi;
        mk.first_val = fv;
        mk.second_val = sv;
        mk.dest_present = dp;
        mk.dest_idx = di;
    endfunction

    // Register port: one-cycle strobes, read data in the following cycle
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_check(input logic [7:0] a, input logic [31:0] want, input string msg);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, want, msg);
    endtask

    // One legal request, judged against the model one cycle later
    task automatic run_op(input req_t r);
        logic [31:0] a;
        logic [31:0] b;
        logic [35:0] res;
        logic [3:0]  dst;
        a = (r.first_idx == PC_IDX) ? (r.first_val & 32'hffff_fffc) : r.first_val;
        b = r.use_imm ? {20'h00000, r.imm} : r.second_val;
        res = calc(r.op, a, b, exp_f[FLAG_C]);
        dst = r.dest_present ? r.dest_idx : r.first_idx;
        @(posedge clk);
        req <= r;
        @(posedge clk);
        req <= '0;
        #1;
        if (r.op == OP_SUM && !r.use_imm && r.first_idx == PC_IDX && dst == PC_IDX) begin
            chk({31'h0, br.valid}, 32'h1, "branch valid");
            chk(br.target, res[31:0] & 32'hffff_fffe, "branch target");
            chk({31'h0, wb.valid}, 32'h0, "no wb on branch");
        end else begin
            chk({31'h0, wb.valid}, 32'h1, "wb valid");
            chk({28'h0, wb.idx}, {28'h0, dst}, "wb idx");
            chk(wb.data, res[31:0], "wb data");
        end
        if (r.set_flags && !r.use_imm)
            exp_f = res[35:32];
        chk({28'h0, flags}, {28'h0, exp_f}, "flags");
    endtask

    task automatic t_reset();
        chk({28'h0, flags}, 32'h0, "flags after reset");
        chk({31'h0, wb.valid}, 32'h0, "wb after reset");
        reg_check(FLAGS_OFF, 32'h0, "flags reg after reset");
        reg_check(8'h40, 32'h0, "unmapped read");
    endtask

    // Plain sums, immediate bounds, default destination
    task automatic t_sum();
        run_op(mk(OP_SUM, 1'b0, 1'b0, 12'h000, 4'h1, 32'h5, 32'h3, 1'b1, 4'h2));
        run_op(mk(OP_SUM, 1'b0, 1'b0, 12'h000, SP_IDX, 32'h2000, 32'h18, 1'b1, SP_IDX));
        run_op(mk(OP_SUM, 1'b1, 1'b1, 12'hfff, 4'h3, 32'h1, 32'h0, 1'b0, 4'h0));
        run_op(mk(OP_DIFF, 1'b1, 1'b1, 12'h000, 4'h4, 32'h0, 32'h0, 1'b1, 4'h5));
        run_op(mk(OP_SUM, 1'b1, 1'b0, 12'h000, 4'h1, 32'h7fff_ffff, 32'h1, 1'b1, 4'h2));
    endtask

    // Subtract flavours and borrow chaining
    task automatic t_sub();
        run_op(mk(OP_DIFF, 1'b1, 1'b0, 12'h000, 4'h6, 32'h3, 32'h3, 1'b1, 4'h7));
        run_op(mk(OP_DIFF, 1'b1, 1'b0, 12'h000, 4'h6, 32'h0, 32'h1, 1'b1, 4'h7));
        run_op(mk(OP_DIFF_BRW, 1'b1, 1'b0, 12'h000, 4'h8, 32'h5, 32'h2, 1'b1, 4'h9));
        run_op(mk(OP_DIFF_BRW, 1'b1, 1'b0, 12'h000, 4'h8, 32'h5, 32'h2, 1'b1, 4'h9));
        run_op(mk(OP_REV_DIFF, 1'b1, 1'b0, 12'h000, 4'ha, 32'h2, 32'h1, 1'b1, 4'hb));
        run_op(mk(OP_REV_DIFF, 1'b1, 1'b0, 12'h000, 4'ha, 32'h2, 32'h9, 1'b0, 4'h0));
    endtask

    // Carry in set by software through the flags register
    task automatic t_carry_reg();
        reg_write(FLAGS_OFF, 32'hffff_fffa);
        exp_f = 4'ha;
        reg_check(FLAGS_OFF, 32'h0000_000a, "flags readback");
        run_op(mk(OP_SUM_CARRY, 1'b0, 1'b0, 12'h000, 4'h1, 32'h10, 32'h20, 1'b1, 4'h2));
    endtask

    // Back-to-back 64-bit add: second request sees the first one's carry
    task automatic t_b2b();
        @(posedge clk);
        req <= mk(OP_SUM, 1'b1, 1'b0, 12'h000, 4'h0, 32'hffff_ffff, 32'h1, 1'b1, 4'h4);
        @(posedge clk);
        req <= mk(OP_SUM_CARRY, 1'b0, 1'b0, 12'h000, 4'h1, 32'h1, 32'h2, 1'b1, 4'h5);
        #1;
        chk(wb.data, 32'h0, "low word");
        @(posedge clk);
        req <= '0;
        #1;
        chk(wb.data, 32'h4, "high word with carry");
        chk({28'h0, flags}, 32'h6, "chained flags");
        exp_f = 4'h6;
    endtask

    // Program counter as base, and the register branch form
    task automatic t_pc();
        run_op(mk(OP_SUM, 1'b0, 1'b1, 12'h010, PC_IDX, 32'h1003, 32'h0, 1'b1, 4'h3));
        run_op(mk(OP_DIFF, 1'b0, 1'b1, 12'h002, PC_IDX, 32'h1006, 32'h0, 1'b1, 4'h3));
        run_op(mk(OP_SUM, 1'b0, 1'b0, 12'h000, PC_IDX, 32'h102, 32'h11, 1'b0, 4'h0));
        run_op(mk(OP_SUM, 1'b0, 1'b0, 12'h000, PC_IDX, 32'h203, 32'h20, 1'b1, PC_IDX));
    endtask

    // Immediate with a carry op is refused: nothing written, counter moves
    task automatic t_refuse();
        @(posedge clk);
        req <= mk(OP_SUM_CARRY, 1'b1, 1'b1, 12'h001, 4'h1, 32'h1, 32'h1, 1'b1, 4'h2);
        @(posedge clk);
        // Op code with two bits set is not one-hot and must be refused too
        req <= mk(op_t'(5'b00011), 1'b1, 1'b0, 12'h000, 4'h1, 32'h1, 32'h1, 1'b1, 4'h2);
        #1;
        chk({31'h0, wb.valid}, 32'h0, "refused wb");
        chk({28'h0, flags}, {28'h0, exp_f}, "refused flags");
        @(posedge clk);
        req <= '0;
        #1;
        chk({31'h0, wb.valid}, 32'h0, "refused op wb");
        chk({28'h0, flags}, {28'h0, exp_f}, "refused op flags");
        reg_check(REJECT_OFF, 32'h2, "reject count");
        // Eighteen taken requests so far; the last one was the 0x220 branch sum
        reg_check(COUNT_OFF, 32'h0000_0012, "taken count");
        reg_check(RESULT_OFF, 32'h0000_0220, "last result");
        reg_write(COUNT_OFF, 32'h0000_0000);
        reg_check(COUNT_OFF, 32'h0000_0012, "count is read only");
    endtask

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        wrap_up();
    end

    // Main sequence
    initial begin
        reset_n = 1'b0;
        req = '0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        exp_f = 4'h0;
        err_count = 0;
        compares = 0;
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        #1;
        t_reset();
        t_sum();
        t_sub();
        t_carry_reg();
        t_b2b();
        t_pc();
        t_refuse();
        wrap_up();
    end
endmodule
